// file: cpm_map.svh
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH
// ************************************************************
// register numbers for the read and write ports
// ************************************************************
`define CPM_RSEL_DATA0 5'h00
`define CPM_RSEL_ADDR0 5'h08
`define CPM_RSEL_SP 5'h0f
`define CPM_RSEL_PC 5'h10
`define CPM_RSEL_PSW 5'h11
`define CPM_RSEL_CFB 5'h12
`define CPM_RSEL_SFC 5'h13
`define CPM_RSEL_DFC 5'h14
`define CPM_RSEL_ETB 5'h15
`define CPM_RSEL_USP 5'h16
`define CPM_RSEL_SSP 5'h17
// ************************************************************
// status word fields
// ************************************************************
`define CPM_PSW_C 0
`define CPM_PSW_V 1
`define CPM_PSW_Z 2
`define CPM_PSW_N 3
`define CPM_PSW_X 4
`define CPM_PSW_IPL_LO 8
`define CPM_PSW_IPL_HI 10
`define CPM_PSW_PRIV 13
`define CPM_PSW_TR_LO 14
`define CPM_PSW_TR_HI 15
`define CPM_PSW_DEF_MASK 16'he71f
`define CPM_CFB_MASK 16'h001f
// ************************************************************
// reset value, function codes and vector table sizes
// ************************************************************
`define CPM_PSW_RESET 16'h2700
`define CPM_FC_MASK 32'h0000_0007
`define CPM_FC_USER_DATA 3'h1
`define CPM_FC_USER_PROG 3'h2
`define CPM_FC_SUP_DATA 3'h5
`define CPM_FC_SUP_PROG 3'h6
`define CPM_FC_CPU 3'h7
`define CPM_VEC_TABLE_BYTES 1024
`define CPM_VEC_COUNT 256
`endif

// file: cpm_pkg.sv
package cpm_pkg;
	typedef enum logic [1:0] {CPM_SZ_BYTE, CPM_SZ_WORD, CPM_SZ_LONG} cpm_size_t;
	typedef enum logic [1:0] {CPM_ACC_PROG, CPM_ACC_DATA, CPM_ACC_CPU, CPM_ACC_ALT} cpm_acc_t;
	typedef logic [4:0] cpm_rsel_t;
endpackage : cpm_pkg

// file: cpm_wr_if.sv
`timescale 1ns/1ps
// write request path between the register file and its merge unit
interface cpm_wr_if;
	logic [1:0] size;
	logic [31:0] old_val;
	logic [31:0] wdata;
	logic is_addr;
	logic [31:0] merged;
	modport core (output size, output old_val, output wdata, output is_addr, input merged);
	modport merge (input size, input old_val, input wdata, input is_addr, output merged);
endinterface : cpm_wr_if

// file: cpm_merge.sv
`timescale 1ns/1ps
`include "cpm_map.svh"
// operand merge for data and address destinations
module cpm_merge (
	cpm_wr_if.merge w
);
	import cpm_pkg::*;
	// data regs keep upper bits; address regs sign-extend word writes
	always_comb begin
		w.merged = w.wdata;
		if (w.is_addr) begin
			if (w.size != 2'(CPM_SZ_LONG))
				w.merged = {{16{w.wdata[15]}}, w.wdata[15:0]};
		end else begin
			unique case (w.size)
				2'(CPM_SZ_BYTE): w.merged = {w.old_val[31:8], w.wdata[7:0]};
				2'(CPM_SZ_WORD): w.merged = {w.old_val[31:16], w.wdata[15:0]};
				default: w.merged = w.wdata;
			endcase
		end
	end
endmodule : cpm_merge

// file: cpm_fcgen.sv
`timescale 1ns/1ps
`include "cpm_map.svh"
// function code generation for each bus access
module cpm_fcgen (
	input wire logic priv_i,
	input wire logic [1:0] acc_i,
	input wire logic alt_dst_i,
	input wire logic [2:0] sfc_i,
	input wire logic [2:0] dfc_i,
	output logic [2:0] fc_o
);
	import cpm_pkg::*;
	// automatic codes unless an alternate-space move names its register
	always_comb begin
		unique case (cpm_acc_t'(acc_i))
			CPM_ACC_PROG: fc_o = priv_i ? `CPM_FC_SUP_PROG : `CPM_FC_USER_PROG;
			CPM_ACC_DATA: fc_o = priv_i ? `CPM_FC_SUP_DATA : `CPM_FC_USER_DATA;
			CPM_ACC_CPU: fc_o = `CPM_FC_CPU;
			CPM_ACC_ALT: fc_o = alt_dst_i ? dfc_i : sfc_i;
		endcase
	end
endmodule : cpm_fcgen

// file: cpm_regs.sv
`timescale 1ns/1ps
`include "cpm_map.svh"
// Operation
// - data, address, pc, stacks, status, codes, base
// - byte/word data writes keep upper bits
// - bit zero is least significant
// - any two data regs hold 64 bits
// - packed decimal low digit in low nibble
// - no byte address ops; word/long reads
// - address writes full, words sign-extended
// - pc holds next instruction address
// - control regs need supervisor privilege
// - low status byte holds user flags
// - upper byte: mask, trace, privilege
// - undefined status bits read zero
// - flag byte writes keep upper byte; reads zero it
// - 3-bit space codes extend 24-bit address
// - automatic function codes per access kind
// - alternate move uses space code regs
// - space code transfers keep three bits
// - table base locates 256-vector table
// - privilege bit selects stack pointer
module cpm_regs (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// write port
	input wire logic wr_en_i,
	input wire cpm_pkg::cpm_rsel_t wr_sel_i,
	input wire cpm_pkg::cpm_size_t wr_size_i,
	input wire logic [31:0] wr_data_i,
	// read port
	input wire logic rd_en_i,
	input wire cpm_pkg::cpm_rsel_t rd_sel_i,
	input wire cpm_pkg::cpm_size_t rd_size_i,
	// program counter control
	input wire logic pc_inc_i,
	input wire logic [1:0] pc_inc_words_i,
	input wire logic pc_load_i,
	input wire logic [31:0] pc_load_val_i,
	// flag update from execution
	input wire logic flags_we_i,
	input wire logic [4:0] flags_i,
	// bus access kind
	input wire cpm_pkg::cpm_acc_t acc_i,
	input wire logic alt_dst_i,
	input wire logic [7:0] vec_num_i,
	// outputs
	output logic [31:0] rd_data_o,
	output logic rd_fault_o,
	output logic wr_fault_o,
	output logic [31:0] pc_o,
	output logic [15:0] psw_o,
	output logic [2:0] fc_o,
	output logic [31:0] vec_addr_o
);
	import cpm_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0][31:0] dreg;
		logic [6:0][31:0] areg;
		logic [31:0] unprivileged_stack_ptr;
		logic [31:0] privileged_stack_ptr;
		logic [31:0] pc;
		logic [15:0] psw;
		logic [2:0] src_space_code_reg;
		logic [2:0] dfc;
		logic [31:0] etb;
		logic [31:0] rd_data;
		logic rd_fault;
		logic wr_fault;
		logic [2:0] fc;
		logic [31:0] vec_addr;
	} cpm_state_t;

	cpm_state_t st_r;
	cpm_state_t st_nxt;
	cpm_wr_if wif ();
	logic [2:0] fc_w;
	logic [31:0] cur_sp;

	// ************************************************************
	// helpers
	// ************************************************************
	// bit 0 is the least significant everywhere in this block
	function automatic logic [31:0] size_read(input logic [31:0] v, input logic [1:0] sz);
		unique case (sz)
			2'(CPM_SZ_BYTE): size_read = {24'h00_0000, v[7:0]};
			2'(CPM_SZ_WORD): size_read = {16'h0000, v[15:0]};
			default: size_read = v;
		endcase
	endfunction : size_read

	function automatic logic is_ctrl(input logic [4:0] sel);
		is_ctrl = (sel == `CPM_RSEL_PSW) || (sel == `CPM_RSEL_SFC) || (sel == `CPM_RSEL_DFC)
			|| (sel == `CPM_RSEL_ETB) || (sel == `CPM_RSEL_USP) || (sel == `CPM_RSEL_SSP);
	endfunction : is_ctrl

	function automatic logic is_areg(input logic [4:0] sel);
		is_areg = (sel >= `CPM_RSEL_ADDR0) && (sel <= `CPM_RSEL_SP);
	endfunction : is_areg

	// ************************************************************
	// submodules
	// ************************************************************
	assign cur_sp = st_r.psw[`CPM_PSW_PRIV] ? st_r.privileged_stack_ptr : st_r.unprivileged_stack_ptr;
	assign wif.size = wr_size_i;
	assign wif.wdata = wr_data_i;
	assign wif.is_addr = is_areg(wr_sel_i);
	// old value only matters for data registers
	assign wif.old_val = (wr_sel_i < `CPM_RSEL_ADDR0) ? st_r.dreg[wr_sel_i[2:0]] : 32'h0000_0000;

	cpm_merge u_merge (
		.w(wif)
	);

	cpm_fcgen u_fcgen (
		.priv_i(st_r.psw[`CPM_PSW_PRIV]),
		.acc_i(acc_i),
		.alt_dst_i(alt_dst_i),
		.sfc_i(st_r.src_space_code_reg),
		.dfc_i(st_r.dfc),
		.fc_o(fc_w)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic priv;
		logic rd_bad;
		logic wr_bad;
		logic [31:0] rv;
		priv = st_r.psw[`CPM_PSW_PRIV];
		rd_bad = 1'b0;
		wr_bad = 1'b0;
		rv = 32'h0000_0000;
		st_nxt = st_r;

		// read path
		if (rd_en_i) begin
			if (is_ctrl(rd_sel_i) && !priv)
				rd_bad = 1'b1;
			else if (is_areg(rd_sel_i) && rd_size_i == CPM_SZ_BYTE)
				rd_bad = 1'b1;
			else if ((rd_sel_i == `CPM_RSEL_PSW || rd_sel_i == `CPM_RSEL_CFB) && rd_size_i != CPM_SZ_WORD)
				rd_bad = 1'b1;
			else if ((rd_sel_i == `CPM_RSEL_SFC || rd_sel_i == `CPM_RSEL_DFC) && rd_size_i != CPM_SZ_LONG)
				rd_bad = 1'b1;
			else begin
				if (rd_sel_i < `CPM_RSEL_ADDR0)
					rv = size_read(st_r.dreg[rd_sel_i[2:0]], rd_size_i);
				else if (rd_sel_i == `CPM_RSEL_SP)
					rv = size_read(cur_sp, rd_size_i);
				else if (is_areg(rd_sel_i))
					rv = size_read(st_r.areg[rd_sel_i[2:0]], rd_size_i);
				else begin
					unique case (rd_sel_i)
						`CPM_RSEL_PC: rv = size_read(st_r.pc, rd_size_i);
						`CPM_RSEL_PSW: rv = {16'h0000, st_r.psw & `CPM_PSW_DEF_MASK};
						`CPM_RSEL_CFB: rv = {16'h0000, st_r.psw & `CPM_CFB_MASK};
						`CPM_RSEL_SFC: rv = {29'h0000_0000, st_r.src_space_code_reg};
						`CPM_RSEL_DFC: rv = {29'h0000_0000, st_r.dfc};
						`CPM_RSEL_ETB: rv = st_r.etb;
						`CPM_RSEL_USP: rv = st_r.unprivileged_stack_ptr;
						`CPM_RSEL_SSP: rv = st_r.privileged_stack_ptr;
						default: rd_bad = 1'b1; // unused selector
					endcase
				end
			end
			st_nxt.rd_data = rv;
		end
		st_nxt.rd_fault = rd_bad;

		// execution flags land first; an explicit write below overrides them
		if (flags_we_i)
			st_nxt.psw[`CPM_PSW_X:`CPM_PSW_C] = flags_i;

		// program counter: a load wins over an advance
		if (pc_load_i)
			st_nxt.pc = pc_load_val_i;
		else if (pc_inc_i)
			st_nxt.pc = st_r.pc + {29'h0000_0000, pc_inc_words_i, 1'b0};

		// write path
		if (wr_en_i) begin
			if (is_ctrl(wr_sel_i) && !priv)
				wr_bad = 1'b1;
			else if (is_areg(wr_sel_i) && wr_size_i == CPM_SZ_BYTE)
				wr_bad = 1'b1;
			else if ((wr_sel_i == `CPM_RSEL_PSW || wr_sel_i == `CPM_RSEL_CFB) && wr_size_i != CPM_SZ_WORD)
				wr_bad = 1'b1;
			else if ((wr_sel_i == `CPM_RSEL_SFC || wr_sel_i == `CPM_RSEL_DFC) && wr_size_i != CPM_SZ_LONG)
				wr_bad = 1'b1;
			else if (wr_sel_i < `CPM_RSEL_ADDR0)
				st_nxt.dreg[wr_sel_i[2:0]] = wif.merged;
			else if (wr_sel_i == `CPM_RSEL_SP) begin
				if (priv)
					st_nxt.privileged_stack_ptr = wif.merged;
				else
					st_nxt.unprivileged_stack_ptr = wif.merged;
			end else if (is_areg(wr_sel_i))
				st_nxt.areg[wr_sel_i[2:0]] = wif.merged;
			else begin
				unique case (wr_sel_i)
					`CPM_RSEL_PC: st_nxt.pc = wr_data_i;
					`CPM_RSEL_PSW: st_nxt.psw = wr_data_i[15:0] & `CPM_PSW_DEF_MASK;
					`CPM_RSEL_CFB: st_nxt.psw = (st_r.psw & ~`CPM_CFB_MASK)
						| (wr_data_i[15:0] & `CPM_CFB_MASK);
					`CPM_RSEL_SFC: st_nxt.src_space_code_reg = wr_data_i[2:0];
					`CPM_RSEL_DFC: st_nxt.dfc = wr_data_i[2:0];
					`CPM_RSEL_ETB: st_nxt.etb = wr_data_i;
					`CPM_RSEL_USP: st_nxt.unprivileged_stack_ptr = wr_data_i;
					`CPM_RSEL_SSP: st_nxt.privileged_stack_ptr = wr_data_i;
					default: wr_bad = 1'b1; // unused selector
				endcase
			end
		end
		st_nxt.wr_fault = wr_bad;

		// bus code and vector address are registered to keep outputs clean
		st_nxt.fc = fc_w;
		st_nxt.vec_addr = st_r.etb + {22'h00_0000, vec_num_i, 2'b00};
	end

	// ************************************************************
	// registers
	// ************************************************************
	// all state frozen while the clock enable is low
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
			st_r.psw <= `CPM_PSW_RESET; // start supervisor, all levels masked
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign rd_data_o = st_r.rd_data;
	assign rd_fault_o = st_r.rd_fault;
	assign wr_fault_o = st_r.wr_fault;
	assign pc_o = st_r.pc;
	assign psw_o = st_r.psw;
	assign fc_o = st_r.fc;
	assign vec_addr_o = st_r.vec_addr;
endmodule : cpm_regs

// file: cpm_regs_sva.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module cpm_regs_sva (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// requests
	input wire logic ce_i,
	input wire logic wr_en_i,
	input wire cpm_pkg::cpm_rsel_t wr_sel_i,
	input wire cpm_pkg::cpm_size_t wr_size_i,
	input wire logic rd_en_i,
	input wire cpm_pkg::cpm_rsel_t rd_sel_i,
	input wire cpm_pkg::cpm_size_t rd_size_i,
	input wire logic pc_inc_i,
	input wire logic [1:0] pc_inc_words_i,
	input wire logic pc_load_i,
	input wire logic [31:0] pc_load_val_i,
	input wire logic flags_we_i,
	input wire logic [4:0] flags_i,
	input wire cpm_pkg::cpm_acc_t acc_i,
	// results
	input wire logic [31:0] rd_data_o,
	input wire logic rd_fault_o,
	input wire logic wr_fault_o,
	input wire logic [31:0] pc_o,
	input wire logic [15:0] psw_o,
	input wire logic [2:0] fc_o
);
	import cpm_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// refusals answer on the next edge
	chk_ctrl_user_rd: assert property (ce_i && rd_en_i && !psw_o[13] && rd_sel_i == 5'h17
		|=> rd_fault_o && rd_data_o == 32'h0) else $error("user control read not refused");
	chk_addr_byte_wr: assert property (ce_i && wr_en_i && wr_sel_i[4:3] == 2'b01 && wr_size_i == CPM_SZ_BYTE
		|=> wr_fault_o) else $error("byte write to address reg not refused");
	chk_psw_undef_zero: assert property ((psw_o & 16'h18e0) == 16'h0)
		else $error("undefined status bit set");
	// flags and pc follow their update inputs
	chk_flag_update: assert property (ce_i && flags_we_i && !wr_en_i |=> psw_o[4:0] == $past(flags_i))
		else $error("flags not updated");
	chk_pc_advance: assert property (ce_i && pc_inc_i && !pc_load_i && !wr_en_i
		|=> pc_o == $past(pc_o) + {$past(pc_inc_words_i), 1'b0}) else $error("pc advance wrong");
	chk_pc_load: assert property (ce_i && pc_load_i && !wr_en_i |=> pc_o == $past(pc_load_val_i))
		else $error("pc load wrong");
	// a low clock enable freezes pc, status, bus code and read data
	chk_ce_hold: assert property (!ce_i |=> $stable(pc_o) && $stable(psw_o) && $stable(fc_o) && $stable(rd_data_o))
		else $error("state moved while clock enable low");
	chk_fc_cpu: assert property (ce_i && acc_i == CPM_ACC_CPU |=> fc_o == 3'h7)
		else $error("cpu space code wrong");
	chk_fc_sup_prog: assert property (ce_i && acc_i == CPM_ACC_PROG && psw_o[13] |=> fc_o == 3'h6)
		else $error("supervisor program code wrong");
	// narrow registers read back zero-filled
	chk_code_rd_zero: assert property (ce_i && rd_en_i && psw_o[13] && rd_sel_i inside {5'h13, 5'h14}
		&& rd_size_i == CPM_SZ_LONG |=> rd_data_o[31:3] == 29'h0 && !rd_fault_o) else $error("code read wrong");
	chk_flag_byte_rd: assert property (ce_i && rd_en_i && rd_sel_i == 5'h12 && rd_size_i == CPM_SZ_WORD
		|=> rd_data_o[31:5] == 27'h0) else $error("flag byte upper bits set");
	// main scenarios
	cov_wr_fault: cover property (wr_fault_o);
	cov_rd_fault: cover property (rd_fault_o);
	cov_pc_inc: cover property (ce_i && pc_inc_i);
endmodule : cpm_regs_sva
bind cpm_regs cpm_regs_sva u_cpm_regs_sva (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .wr_en_i(wr_en_i),
	.wr_sel_i(wr_sel_i), .wr_size_i(wr_size_i), .rd_en_i(rd_en_i), .rd_sel_i(rd_sel_i), .rd_size_i(rd_size_i),
	.pc_inc_i(pc_inc_i), .pc_inc_words_i(pc_inc_words_i), .pc_load_i(pc_load_i), .pc_load_val_i(pc_load_val_i),
	.flags_we_i(flags_we_i), .flags_i(flags_i), .acc_i(acc_i), .rd_data_o(rd_data_o), .rd_fault_o(rd_fault_o),
	.wr_fault_o(wr_fault_o), .pc_o(pc_o), .psw_o(psw_o), .fc_o(fc_o));

// file: cpu_programming_model_regs_tb_top.sv
`timescale 1ns/1ps
// ****
// bench top
// ****
module cpu_programming_model_regs_tb_top;
	import cpm_pkg::*;
	logic clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0, alt_dst_i = 1'b0;
	logic pc_inc_i = 1'b0, pc_load_i = 1'b0, flags_we_i = 1'b0, rd_fault_o, wr_fault_o, tk_w = 1'b0, tk_r = 1'b0;
	cpm_rsel_t wr_sel_i = 5'h0, rd_sel_i = 5'h0;
	cpm_size_t wr_size_i = CPM_SZ_LONG, rd_size_i = CPM_SZ_LONG;
	cpm_acc_t acc_i = CPM_ACC_DATA;
	logic [1:0] pc_inc_words_i = 2'h0;
	logic [4:0] flags_i = 5'h0;
	logic [7:0] vec_num_i = 8'h0;
	logic [31:0] wr_data_i = 32'h0, pc_load_val_i = 32'h0, rd_data_o, pc_o, vec_addr_o, r;
	logic [15:0] psw_o;
	logic [2:0] fc_o;
	logic [34:0] q[$], e;
	int err_total = 0, check_count = 0;
	cpm_regs u_cpm_regs (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i),
		.wr_size_i(wr_size_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_sel_i(rd_sel_i), .rd_size_i(rd_size_i),
		.pc_inc_i(pc_inc_i), .pc_inc_words_i(pc_inc_words_i), .pc_load_i(pc_load_i), .pc_load_val_i(pc_load_val_i),
		.flags_we_i(flags_we_i), .flags_i(flags_i), .acc_i(acc_i), .alt_dst_i(alt_dst_i), .vec_num_i(vec_num_i),
		.rd_data_o(rd_data_o), .rd_fault_o(rd_fault_o), .wr_fault_o(wr_fault_o), .pc_o(pc_o), .psw_o(psw_o),
		.fc_o(fc_o), .vec_addr_o(vec_addr_o));
	// 25 ns period
	always #12.5 clk_i = ~clk_i;
	task automatic check(input string n, input logic [34:0] s, input logic [34:0] x);
		check_count++;
		if (s !== x) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask : check
	// one request a cycle; the note goes in the queue as it is driven
	task automatic wr(input cpm_rsel_t s, input cpm_size_t z, input logic [31:0] d, input logic f);
		rd_en_i = 1'b0;
		wr_en_i = 1'b1;
		wr_sel_i = s;
		wr_size_i = z;
		wr_data_i = d;
		q.push_back({1'b0, f, 33'h0});
		@(negedge clk_i);
	endtask : wr
	task automatic rd(input cpm_rsel_t s, input cpm_size_t z, input logic [31:0] d, input logic f);
		wr_en_i = 1'b0;
		rd_en_i = 1'b1;
		rd_sel_i = s;
		rd_size_i = z;
		q.push_back({2'b10, f, d});
		@(negedge clk_i);
	endtask : rd
	task automatic idle(input int n);
		wr_en_i = 1'b0;
		rd_en_i = 1'b0;
		pc_inc_i = 1'b0;
		pc_load_i = 1'b0;
		flags_we_i = 1'b0;
		repeat (n) @(negedge clk_i);
	endtask : idle
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// note which edges took a request; results settle by the falling edge
	always @(posedge clk_i) begin
		tk_w <= ce_i && wr_en_i && rstn_i;
		tk_r <= ce_i && rd_en_i && rstn_i;
	end
	always @(negedge clk_i) begin
		if (tk_w || tk_r) begin
			e = q.pop_front();
			check("wr_fault_o", wr_fault_o, e[33]);
			if (e[34]) check("rd_result", {rd_fault_o, rd_data_o}, e[32:0]);
		end
	end
	// generous bound; the sequence needs under a hundred cycles
	initial begin
		#(25 * 5000);
		err_total++;
		report_and_stop();
	end
	initial begin
		r = $urandom(32'hae1f86d3);
		repeat (2) @(negedge clk_i);
		check("psw_o", psw_o, 16'h2700);
		rstn_i = 1'b1;
		@(negedge clk_i);
		r = $urandom();
		wr(5'h01, CPM_SZ_LONG, ~r, 1'b0);
		wr(5'h00, CPM_SZ_LONG, r, 1'b0);
		wr(5'h00, CPM_SZ_BYTE, 32'h59, 1'b0);
		rd(5'h00, CPM_SZ_LONG, {r[31:8], 8'h59}, 1'b0);
		wr(5'h00, CPM_SZ_WORD, 32'hffffa5c3, 1'b0);
		rd(5'h00, CPM_SZ_LONG, {r[31:16], 16'ha5c3}, 1'b0);
		rd(5'h01, CPM_SZ_LONG, ~r, 1'b0);
		wr(5'h08, CPM_SZ_WORD, 32'h12348000, 1'b0);
		wr(5'h08, CPM_SZ_BYTE, 32'h11, 1'b1);
		rd(5'h08, CPM_SZ_LONG, 32'hffff8000, 1'b0);
		wr(5'h11, CPM_SZ_WORD, 32'hffff, 1'b0);
		rd(5'h11, CPM_SZ_WORD, 32'he71f, 1'b0);
		wr(5'h12, CPM_SZ_WORD, 32'hff0a, 1'b0);
		rd(5'h12, CPM_SZ_WORD, 32'h0a, 1'b0);
		rd(5'h11, CPM_SZ_WORD, 32'he70a, 1'b0);
		wr(5'h12, CPM_SZ_BYTE, 32'h1, 1'b1);
		idle(0);
		// flags, pc advance and cpu code in one cycle, then load beats advance
		flags_i = r[4:0];
		flags_we_i = 1'b1;
		pc_inc_words_i = 2'h3;
		pc_inc_i = 1'b1;
		vec_num_i = 8'hff;
		acc_i = CPM_ACC_CPU;
		@(negedge clk_i);
		check("psw_flags", psw_o[4:0], r[4:0]);
		check("pc_o", pc_o, 32'h6);
		check("fc_o", fc_o, 3'h7);
		pc_load_val_i = r;
		pc_load_i = 1'b1;
		acc_i = CPM_ACC_PROG;
		@(negedge clk_i);
		check("pc_o", pc_o, r);
		check("fc_o", fc_o, 3'h6);
		// clock enable low: the advance and the code change must wait
		ce_i = 1'b0;
		pc_load_i = 1'b0;
		acc_i = CPM_ACC_CPU;
		@(negedge clk_i);
		check("pc_o", pc_o, r);
		check("fc_o", fc_o, 3'h6);
		ce_i = 1'b1;
		@(negedge clk_i);
		check("pc_o", pc_o, r + 32'h6);
		check("fc_o", fc_o, 3'h7);
		idle(1);
		wr(5'h13, CPM_SZ_LONG, 32'hfffffffe, 1'b0);
		wr(5'h14, CPM_SZ_LONG, 32'h3, 1'b0);
		wr(5'h13, CPM_SZ_WORD, 32'h1, 1'b1);
		rd(5'h13, CPM_SZ_LONG, 32'h6, 1'b0);
		wr(5'h15, CPM_SZ_LONG, 32'h10000, 1'b0);
		idle(1);
		acc_i = CPM_ACC_ALT;
		@(negedge clk_i);
		check("fc_o", fc_o, 3'h6);
		check("vec_addr_o", vec_addr_o, 32'h103fc);
		alt_dst_i = 1'b1;
		@(negedge clk_i);
		check("fc_o", fc_o, 3'h3);
		acc_i = CPM_ACC_DATA;
		@(negedge clk_i);
		check("fc_o", fc_o, 3'h5);
		// both stacks kept; alias follows privilege
		wr(5'h16, CPM_SZ_LONG, r, 1'b0);
		wr(5'h0f, CPM_SZ_LONG, ~r, 1'b0);
		rd(5'h17, CPM_SZ_LONG, ~r, 1'b0);
		rd(5'h16, CPM_SZ_LONG, r, 1'b0);
		wr(5'h11, CPM_SZ_WORD, 32'h0, 1'b0);
		rd(5'h0f, CPM_SZ_LONG, r, 1'b0);
		rd(5'h17, CPM_SZ_LONG, 32'h0, 1'b1);
		wr(5'h15, CPM_SZ_LONG, 32'h0, 1'b1);
		rd(5'h12, CPM_SZ_WORD, 32'h0, 1'b0);
		rd(5'h18, CPM_SZ_LONG, 32'h0, 1'b1);
		idle(1);
		acc_i = CPM_ACC_PROG;
		@(negedge clk_i);
		check("fc_o", fc_o, 3'h2);
		// second reset in mid-run
		rstn_i = 1'b0;
		@(negedge clk_i);
		check("psw_o", psw_o, 16'h2700);
		check("pc_o", pc_o, 32'h0);
		rstn_i = 1'b1;
		idle(2);
		check("notes_left", q.size(), 35'h0);
		report_and_stop();
	end
endmodule : cpu_programming_model_regs_tb_top
